// ===== hdl/qstat_pkg.sv
package qstat_pkg;
   localparam int NCHAN = 4;
   localparam int NWIN  = 2;
   localparam int NLM   = 8;
   localparam int FW    = 15;
   localparam int NREG  = NCHAN * NWIN + 4 * NCHAN;
   localparam int IW    = 5;

   typedef logic [FW-1:0] flags_t;

   localparam flags_t EN_RST  = 15'h0000;
   localparam flags_t PTR_RST = 15'h7fff;
   localparam flags_t NTR_RST = 15'h0000;

   localparam int DC_SUPPLY_BIT = 0;
   localparam int DC_TUNE_BIT   = 1;
   localparam int DC_AUX_BIT    = 2;
   localparam int PN_NOSIG_BIT  = 1;
   localparam int TEMP_DEV_BIT  = 0;
   localparam int TIME_SWEEP_BIT = 1;

   typedef enum logic [3:0] {
      OP_NOP       = 4'h0,
      OP_QCOND     = 4'h1,
      OP_QEVENT    = 4'h2,
      OP_QENABLE   = 4'h3,
      OP_WENABLE   = 4'h4,
      OP_WPTR      = 4'h5,
      OP_WNTR      = 4'h6,
      OP_CLS       = 4'h7,
      OP_STPRESET  = 4'h8,
      OP_RST       = 4'h9,
      OP_SYSPRESET = 4'ha,
      OP_DCL       = 4'hb,
      OP_SDC       = 4'hc,
      OP_PON       = 4'hd
   } op_t;

   typedef enum logic [2:0] {
      K_LIMIT = 3'h0,
      K_DCSUP = 3'h1,
      K_PNAPP = 3'h2,
      K_TEMP  = 3'h3,
      K_TIME  = 3'h4
   } kind_t;

   typedef struct packed {
      logic        valid;
      op_t         op;
      kind_t       kind;
      logic [1:0]  chan;
      logic        win;
      logic [15:0] data;
   } cmd_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } rsp_t;

   typedef struct packed {
      logic clr_event;
      logic preset;
      logic clr_stb_esr;
      logic clr_sre_ese_ppe;
      logic clr_errq;
      logic clr_outbuf;
      logic clr_inbuf;
      logic settings_rst;
   } resets_t;

   typedef logic [NCHAN-1:0][NWIN-1:0][NLM-1:0] lm_in_t;
endpackage

// ===== hdl/status_cell.sv
`timescale 1ns/100ps
module status_cell
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire qstat_pkg::flags_t cond,
   input  wire logic              clr_event,
   input  wire logic              preset,
   input  wire logic              rd_clr,
   input  wire logic              wr_en,
   input  wire logic              wr_ptr,
   input  wire logic              wr_ntr,
   input  wire qstat_pkg::flags_t wr_data,
   output qstat_pkg::flags_t      cond_q,
   output qstat_pkg::flags_t      event_q,
   output qstat_pkg::flags_t      enable_q
);
   import qstat_pkg::*;

   flags_t ptr_q;
   flags_t ntr_q;
   flags_t hit;
   flags_t event_d;
   flags_t enable_d;
   flags_t ptr_d;
   flags_t ntr_d;

   // edge filters feed the sticky event part; a new hit beats a clear
   assign hit      = (cond & ~cond_q & ptr_q) | (~cond & cond_q & ntr_q);
   assign event_d  = hit | ((clr_event | rd_clr) ? '0 : event_q);
   assign enable_d = preset ? EN_RST : (wr_en ? wr_data : enable_q);
   assign ptr_d    = preset ? PTR_RST : (wr_ptr ? wr_data : ptr_q);
   assign ntr_d    = preset ? NTR_RST : (wr_ntr ? wr_data : ntr_q);

   // condition tracks live state, the rest hold
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         cond_q   <= '0;
         event_q  <= '0;
         enable_q <= EN_RST;
         ptr_q    <= PTR_RST;
         ntr_q    <= NTR_RST;
      end
      else
      begin
         cond_q   <= cond;
         event_q  <= event_d;
         enable_q <= enable_d;
         ptr_q    <= ptr_d;
         ntr_q    <= ntr_d;
      end
   end
endmodule // status_cell

// ===== hdl/reset_ctrl.sv
`timescale 1ns/100ps
module reset_ctrl
(
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire logic          cmd_valid,
   input  wire qstat_pkg::op_t op,
   input  wire logic          psc_flag,
   input  wire logic          msg_term,
   output qstat_pkg::resets_t resets_q
);
   import qstat_pkg::*;

   logic    pon;
   logic    pon_clr;
   logic    cls;
   logic    stp;
   logic    rstc;
   logic    dev_clr;
   logic    defer;
   logic    fire;
   logic    pend_q;
   logic    line_q;
   resets_t resets_d;

   // command decode
   assign pon     = cmd_valid && (op == OP_PON);
   assign pon_clr = pon && psc_flag;
   assign cls     = cmd_valid && (op == OP_CLS);
   assign stp     = cmd_valid && (op == OP_STPRESET);
   assign rstc    = cmd_valid && (op == OP_RST || op == OP_SYSPRESET);
   assign dev_clr = cmd_valid && (op == OP_DCL || op == OP_SDC);
   assign defer   = cls | stp | rstc;
   assign fire    = cmd_valid && line_q && pend_q;

   // effect table
   assign resets_d.clr_event       = pon_clr | cls;
   assign resets_d.clr_stb_esr     = pon_clr | cls;
   assign resets_d.clr_sre_ese_ppe = pon_clr;
   assign resets_d.preset          = pon_clr | stp;
   assign resets_d.clr_errq        = pon | cls;
   assign resets_d.clr_outbuf      = pon | dev_clr | fire;
   assign resets_d.clr_inbuf       = pon | dev_clr;
   assign resets_d.settings_rst    = rstc;

   // pending output clear waits for a new line; a new request wins
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pend_q   <= 1'b0;
         line_q   <= 1'b0;
         resets_q <= '0;
      end
      else
      begin
         pend_q   <= defer | (pend_q & ~fire & ~pon & ~dev_clr);
         line_q   <= msg_term | (line_q & ~cmd_valid);
         resets_q <= resets_d;
      end
   end
endmodule // reset_ctrl

// ===== hdl/qstat_regs.sv
`timescale 1ns/100ps
module qstat_regs
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire qstat_pkg::cmd_t   cmd,
   input  wire logic              msg_term,
   input  wire logic              psc_flag,
   input  wire logic              pn_present,
   input  wire qstat_pkg::lm_in_t lm_fail,
   input  wire logic [3:0][2:0]   dc_fault,
   input  wire logic [3:0]        sig_lost,
   input  wire logic [3:0]        temp_dev,
   input  wire logic              warmup,
   input  wire logic [3:0]        sweep_low,
   output qstat_pkg::rsp_t        rsp_q,
   output qstat_pkg::resets_t     resets_q,
   output logic [4:0]             summary_q
);
   import qstat_pkg::*;

   // flat index of a sub-register
   function automatic logic [IW-1:0] reg_idx(input kind_t k, input int c, input int w);
      int n;
      n = 0;
      if (k == K_LIMIT)
         n = c * NWIN + w;
      else
         n = NCHAN * NWIN + (int'(k) - 1) * NCHAN + c;
      return IW'(n);
   endfunction

   flags_t [NREG-1:0] cond_all;
   flags_t [NREG-1:0] cq_all;
   flags_t [NREG-1:0] ev_all;
   flags_t [NREG-1:0] en_all;
   logic   [NREG-1:0] rd_clr_v;
   logic   [NREG-1:0] wr_en_v;
   logic   [NREG-1:0] wr_ptr_v;
   logic   [NREG-1:0] wr_ntr_v;
   logic   [4:0][NREG-1:0] kind_hit;

   logic        kind_ok;
   logic        app_ok;
   logic        acc_ok;
   logic [IW-1:0] idx;
   logic        is_query;
   flags_t      rd_val;
   rsp_t        rsp_d;
   logic [4:0]  summary_d;
   resets_t     rs;

   // command and reset sequencing
   reset_ctrl u_reset_ctrl
   (
      .clock     (clock),
      .rst       (rst),
      .cmd_valid (cmd.valid),
      .op        (cmd.op),
      .psc_flag  (psc_flag),
      .msg_term  (msg_term),
      .resets_q  (rs)
   );
   assign resets_q = rs;

   // access decode
   assign kind_ok  = (cmd.kind <= K_TIME);
   assign app_ok   = pn_present || !(cmd.kind == K_DCSUP || cmd.kind == K_PNAPP);
   assign acc_ok   = cmd.valid && kind_ok && app_ok;
   assign idx      = reg_idx(cmd.kind, int'(cmd.chan), int'(cmd.win));
   assign is_query = cmd.valid &&
                     (cmd.op == OP_QCOND || cmd.op == OP_QEVENT || cmd.op == OP_QENABLE);

   // limit margin cells, one per channel and window
   genvar c, w, i;
   generate
      for (c = 0; c < NCHAN; c++)
      begin : g_chan
         for (w = 0; w < NWIN; w++)
         begin : g_win
            assign cond_all[reg_idx(K_LIMIT, c, w)] =
               {{(FW - NLM){1'b0}}, lm_fail[c][w]};
         end
         // per channel dc, phase-noise, temperature, time
         assign cond_all[reg_idx(K_DCSUP, c, 0)] = pn_present ?
            {12'h000,
             dc_fault[c][DC_AUX_BIT],
             dc_fault[c][DC_TUNE_BIT],
             dc_fault[c][DC_SUPPLY_BIT]}
            : '0;
         assign cond_all[reg_idx(K_PNAPP, c, 0)] =
            flags_t'({14'h0000, pn_present & sig_lost[c]}) << PN_NOSIG_BIT;
         assign cond_all[reg_idx(K_TEMP, c, 0)] =
            flags_t'({14'h0000, temp_dev[c] | warmup}) << TEMP_DEV_BIT;
         assign cond_all[reg_idx(K_TIME, c, 0)] =
            flags_t'({14'h0000, sweep_low[c]}) << TIME_SWEEP_BIT;
      end

      // status cells and their strobes
      for (i = 0; i < NREG; i++)
      begin : g_cell
         assign rd_clr_v[i] = acc_ok && idx == IW'(i) && cmd.op == OP_QEVENT;
         assign wr_en_v[i]  = acc_ok && idx == IW'(i) && cmd.op == OP_WENABLE;
         assign wr_ptr_v[i] = acc_ok && idx == IW'(i) && cmd.op == OP_WPTR;
         assign wr_ntr_v[i] = acc_ok && idx == IW'(i) && cmd.op == OP_WNTR;

         status_cell u_cell
         (
            .clock     (clock),
            .rst       (rst),
            .cond      (cond_all[i]),
            .clr_event (rs.clr_event),
            .preset    (rs.preset),
            .rd_clr    (rd_clr_v[i]),
            .wr_en     (wr_en_v[i]),
            .wr_ptr    (wr_ptr_v[i]),
            .wr_ntr    (wr_ntr_v[i]),
            .wr_data   (cmd.data[FW-1:0]),
            .cond_q    (cq_all[i]),
            .event_q   (ev_all[i]),
            .enable_q  (en_all[i])
         );

         // enabled events summarised per register kind
         assign kind_hit[0][i] = (i < NCHAN * NWIN) && |(ev_all[i] & en_all[i]);
         assign kind_hit[1][i] = (int'(reg_idx(K_DCSUP, 0, 0)) <= i) &&
                                 (i < int'(reg_idx(K_PNAPP, 0, 0))) &&
                                 |(ev_all[i] & en_all[i]);
         assign kind_hit[2][i] = (int'(reg_idx(K_PNAPP, 0, 0)) <= i) &&
                                 (i < int'(reg_idx(K_TEMP, 0, 0))) &&
                                 |(ev_all[i] & en_all[i]);
         assign kind_hit[3][i] = (int'(reg_idx(K_TEMP, 0, 0)) <= i) &&
                                 (i < int'(reg_idx(K_TIME, 0, 0))) &&
                                 |(ev_all[i] & en_all[i]);
         assign kind_hit[4][i] = (int'(reg_idx(K_TIME, 0, 0)) <= i) &&
                                 |(ev_all[i] & en_all[i]);
      end

      for (i = 0; i < 5; i++)
      begin : g_sum
         assign summary_d[i] = |kind_hit[i];
      end
   endgenerate

   // read selection; missing application registers read zero
   assign rd_val = !(kind_ok && app_ok)     ? '0 :
                   (cmd.op == OP_QCOND)     ? cq_all[idx] :
                   (cmd.op == OP_QEVENT)    ? ev_all[idx] :
                   en_all[idx];
   assign rsp_d.valid = is_query;
   assign rsp_d.data  = is_query ? {1'b0, rd_val} : 16'h0000;

   // registered answer and summary
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         rsp_q     <= '0;
         summary_q <= '0;
      end
      else
      begin
         rsp_q     <= rsp_d;
         summary_q <= summary_d;
      end
   end
endmodule // qstat_regs

// ===== verif/qstat_regs_sva.sv
`timescale 1ns/100ps
module qstat_regs_chk
(
   input wire logic               clock,
   input wire logic               rst,
   input wire qstat_pkg::cmd_t    cmd,
   input wire logic               psc_flag,
   input wire qstat_pkg::rsp_t    rsp_q,
   input wire qstat_pkg::resets_t resets_q
);
   import qstat_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // command classes taken at an edge
   sequence s_query;
      cmd.valid && cmd.op inside {OP_QCOND, OP_QEVENT, OP_QENABLE};
   endsequence
   sequence s_pon;
      cmd.valid && cmd.op == OP_PON;
   endsequence
   sequence s_devclr;
      cmd.valid && cmd.op inside {OP_DCL, OP_SDC};
   endsequence
   // query request seen at an edge
   logic q_req;
   assign q_req = cmd.valid && cmd.op inside {OP_QCOND, OP_QEVENT, OP_QENABLE};
   a_bit15_zero: assert property (!rsp_q.data[15])
      else $error("answer bit 15 set");
   a_idle_data: assert property (!rsp_q.valid |-> rsp_q.data == 16'h0000)
      else $error("idle answer not zero");
   a_query_answer: assert property (s_query |=> rsp_q.valid)
      else $error("query not answered");
   a_answer_cause: assert property (rsp_q.valid |-> $past(q_req))
      else $error("answer without query");
   a_pon_buffers: assert property (
      s_pon |=> resets_q.clr_errq && resets_q.clr_outbuf && resets_q.clr_inbuf)
      else $error("power-on left buffers");
   a_pon_status: assert property (
      s_pon ##0 psc_flag |=> resets_q.clr_event && resets_q.preset
      && resets_q.clr_stb_esr && resets_q.clr_sre_ese_ppe)
      else $error("power-on kept status");
   a_dcl_keeps: assert property (
      s_devclr |=> resets_q.clr_inbuf && resets_q.clr_outbuf && !resets_q.settings_rst
      && !resets_q.clr_event && !resets_q.preset)
      else $error("device clear wrong");
   a_settings_src: assert property (
      resets_q.settings_rst |-> $past(cmd.valid && cmd.op inside {OP_RST, OP_SYSPRESET}))
      else $error("settings reset without cause");
   a_cls_clears: assert property (
      cmd.valid && cmd.op == OP_CLS |=> resets_q.clr_event
      && resets_q.clr_errq && resets_q.clr_stb_esr && !resets_q.clr_inbuf)
      else $error("clear status wrong");
   a_preset_src: assert property (
      resets_q.preset |-> $past(cmd.valid) &&
      ($past(cmd.op) == OP_STPRESET || ($past(cmd.op) == OP_PON && $past(psc_flag))))
      else $error("preset without cause");
   a_outbuf_cause: assert property (resets_q.clr_outbuf |-> $past(cmd.valid))
      else $error("output clear without command");
endmodule // qstat_regs_chk

bind qstat_regs qstat_regs_chk u_chk (.clock(clock), .rst(rst), .cmd(cmd),
   .psc_flag(psc_flag), .rsp_q(rsp_q), .resets_q(resets_q));

// ===== verif/remote_ctrl.sv
`timescale 1ns/100ps
module remote_ctrl
(
   input  wire logic               clock,
   input  wire qstat_pkg::rsp_t    rsp_q,
   input  wire qstat_pkg::resets_t resets_q,
   output qstat_pkg::cmd_t         cmd,
   output logic                    msg_term
);
   import qstat_pkg::*;
   initial
   begin
      cmd = '0;
      msg_term = 1'b0;
   end
   // one command pulse; answer taken in the following cycle
   task automatic issue(input op_t op, input kind_t k, input logic [2:0] cw,
                        input logic [15:0] d, output rsp_t r, output resets_t s);
      @(negedge clock);
      cmd = '{1'b1, op, k, cw[2:1], cw[0], d};
      @(negedge clock);
      r = rsp_q;
      s = resets_q;
      cmd = cmd_t'({1'b0, ~cmd[25:0]}); // idle fields scrambled
   endtask
   // program message terminator pulse
   task automatic terminate();
      @(negedge clock);
      msg_term = 1'b1;
      @(negedge clock);
      msg_term = 1'b0;
   endtask
endmodule // remote_ctrl

// ===== verif/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
   import qstat_pkg::*;
   logic             clock, rst, msg_term, psc_flag, pn_present, warmup;
   lm_in_t           lm_fail;
   logic [3:0][2:0]  dc_fault;
   logic [3:0]       sig_lost, temp_dev, sweep_low;
   logic [4:0]       summary_q;
   cmd_t             cmd;
   rsp_t             rsp_q, r;
   resets_t          resets_q, s;
   int               num_errors = 0;
   int               checks_done = 0;
   op_t              ops[6] = '{OP_PON, OP_PON, OP_DCL, OP_SDC, OP_RST, OP_SYSPRESET};
   logic [7:0]       ex[6] = '{8'h0e, 8'hfe, 8'h06, 8'h06, 8'h01, 8'h01};

   qstat_regs dut (.clock(clock), .rst(rst), .cmd(cmd), .msg_term(msg_term),
      .psc_flag(psc_flag), .pn_present(pn_present), .lm_fail(lm_fail), .dc_fault(dc_fault),
      .sig_lost(sig_lost), .temp_dev(temp_dev), .warmup(warmup), .sweep_low(sweep_low),
      .rsp_q(rsp_q), .resets_q(resets_q), .summary_q(summary_q));
   remote_ctrl u_ctrl (.clock(clock), .rsp_q(rsp_q), .resets_q(resets_q), .cmd(cmd),
      .msg_term(msg_term));

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic close_out();
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic settle();
      repeat (3) @(negedge clock);
   endtask
   // query and compare the answer
   task automatic q(input op_t op, input kind_t k, input logic [2:0] cw, input flags_t e);
      u_ctrl.issue(op, k, cw, 16'h0000, r, s);
      `CHK(r, {1'b1, 1'b0, e})
   endtask
   task automatic t_limit();
      for (int n = 0; n < NLM; n++)
      begin
         lm_fail = '0;
         lm_fail[3][1][n] = 1'b1;
         settle();
         q(OP_QCOND, K_LIMIT, 3'b111, 15'(1 << n));
         q(OP_QCOND, K_LIMIT, 3'b110, 15'h0000);
      end
      lm_fail = '0;
   endtask
   task automatic t_supply();
      dc_fault[2] = 3'b101;
      sig_lost[2] = 1'b1;
      settle();
      q(OP_QCOND, K_DCSUP, 3'b100, 15'h0005);
      dc_fault[2] = 3'b010;
      settle();
      q(OP_QCOND, K_DCSUP, 3'b100, 15'h0002);
      q(OP_QCOND, K_PNAPP, 3'b100, 15'h0002);
      q(OP_QCOND, K_DCSUP, 3'b010, 15'h0000);
      q(OP_QCOND, kind_t'(3'h5), 3'b000, 15'h0000);
      pn_present = 1'b0;
      settle();
      q(OP_QCOND, K_DCSUP, 3'b100, 15'h0000);
      q(OP_QCOND, K_PNAPP, 3'b100, 15'h0000);
      u_ctrl.issue(OP_WENABLE, K_DCSUP, 3'b100, 16'h7fff, r, s);
      dc_fault = '0;
      sig_lost = '0;
      pn_present = 1'b1;
      q(OP_QENABLE, K_DCSUP, 3'b100, 15'h0000);
   endtask
   task automatic t_temp();
      warmup = 1'b1;
      settle();
      q(OP_QCOND, K_TEMP, 3'b110, 15'h0001);
      warmup = 1'b0;
      temp_dev[1] = 1'b1;
      sweep_low[3] = 1'b1;
      settle();
      q(OP_QCOND, K_TEMP, 3'b000, 15'h0000);
      q(OP_QCOND, K_TEMP, 3'b010, 15'h0001);
      q(OP_QCOND, K_TIME, 3'b110, 15'h0002);
      q(OP_QCOND, K_TIME, 3'b010, 15'h0000);
      temp_dev = '0;
      sweep_low = '0;
   endtask
   task automatic t_event();
      sweep_low[0] = 1'b1;
      settle();
      q(OP_QEVENT, K_TIME, 3'b000, 15'h0002);
      q(OP_QEVENT, K_TIME, 3'b000, 15'h0000);
      q(OP_QCOND, K_TIME, 3'b000, 15'h0002);
      u_ctrl.issue(OP_WNTR, K_TIME, 3'b000, 16'h0002, r, s);
      u_ctrl.issue(OP_WPTR, K_TIME, 3'b010, 16'h0000, r, s);
      sweep_low = 4'b0010;
      settle();
      q(OP_QEVENT, K_TIME, 3'b000, 15'h0002);
      q(OP_QEVENT, K_TIME, 3'b010, 15'h0000);
      q(OP_QCOND, K_TIME, 3'b010, 15'h0002);
      sweep_low = '0;
   endtask
   task automatic t_resets();
      u_ctrl.issue(OP_WENABLE, K_TIME, 3'b100, 16'h7fff, r, s);
      sweep_low[2] = 1'b1;
      settle();
      `CHK(summary_q, 5'h10)
      u_ctrl.issue(OP_CLS, K_LIMIT, 3'b000, 16'h0000, r, s);
      `CHK(8'(s), 8'ha8)
      `CHK(r, 17'h00000)
      settle();
      `CHK(summary_q, 5'h00)
      u_ctrl.issue(OP_STPRESET, K_LIMIT, 3'b000, 16'h0000, r, s);
      `CHK(8'(s), 8'h40)
      q(OP_QENABLE, K_TIME, 3'b100, 15'h0000);
      foreach (ops[i])
      begin
         psc_flag = (i == 1);
         u_ctrl.issue(ops[i], K_LIMIT, 3'b000, 16'h0000, r, s);
         `CHK(8'(s), ex[i])
      end
      u_ctrl.terminate();
      u_ctrl.issue(OP_NOP, K_LIMIT, 3'b000, 16'h0000, r, s);
      `CHK(8'(s), 8'h04)
      u_ctrl.issue(OP_NOP, K_LIMIT, 3'b000, 16'h0000, r, s);
      `CHK(8'(s), 8'h00)
      sweep_low = '0;
   endtask
   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      close_out();
   end
   initial
   begin
      rst = 1'b1;
      psc_flag = 1'b0;
      pn_present = 1'b1;
      warmup = 1'b0;
      lm_fail = '0;
      dc_fault = '0;
      sig_lost = '0;
      temp_dev = '0;
      sweep_low = '0;
      repeat (4) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      t_limit();
      t_supply();
      t_temp();
      t_event();
      t_resets();
      close_out();
   end
endmodule // testbench
